// ==== hdl/page_map_consts.svh ====
// Constants for the program space page mapper
`ifndef PAGE_MAP_CONSTS_SVH
`define PAGE_MAP_CONSTS_SVH

`define PC_WIDTH 12
`define PC_MSB 11
`define OFFSET_WIDTH 11
`define PAGE_WIDTH 2
`define PHYS_WIDTH 13
`define DATA_ADDR_WIDTH 8
`define DATA_WIDTH 8
`define PAGE_SEL_ADDR 8'hCA
`define PAGE_SEL_LSB 0
`define PAGE_SEL_RST 2'h0
`define STATIC_PAGE 2'h1

`endif

// ==== hdl/page_map_pkg.sv ====
// Types for the program space page mapper
`include "page_map_consts.svh"
package page_map_pkg;
  typedef logic [`PC_WIDTH-1:0] pc_t;
  typedef logic [`PAGE_WIDTH-1:0] page_t;
  typedef logic [`PHYS_WIDTH-1:0] phys_t;

  typedef enum logic [1:0] {
    SEL_UNKNOWN = 2'h1,
    SEL_KNOWN = 2'h2
  } sel_state_t;

  // Physical address for a program counter and a page code
  function automatic phys_t phys_of(input pc_t pc, input page_t code);
    page_t page;
    page = pc[`PC_MSB] ? `STATIC_PAGE : code;
    return {page, pc[`OFFSET_WIDTH-1:0]};
  endfunction
endpackage

// ==== hdl/page_map_if.sv ====
// Carrier between the mapper control and its address decoder
`timescale 1ns/1ps
`include "page_map_consts.svh"
interface page_map_if;
  logic [`PC_WIDTH-1:0] pc;
  logic [`PAGE_WIDTH-1:0] code;
  logic [`PHYS_WIDTH-1:0] phys;
  logic upper_hit;
  modport decoder (input pc, input code, output phys, output upper_hit);
  modport control (output pc, output code, input phys, input upper_hit);
endinterface

// ==== hdl/page_decode.sv ====
// Combinational program counter to physical address decoder
`timescale 1ns/1ps
`include "page_map_consts.svh"
module page_decode (
  page_map_if.decoder map
);
  // Upper range always lands in the static page
  assign map.upper_hit = map.pc[`PC_MSB];
  // Page number joined to the in-page offset
  assign map.phys = page_map_pkg::phys_of(map.pc, map.code);
endmodule

// ==== hdl/program_space_page_mapper.sv ====
// Program space page mapper with its write-only page select register
`timescale 1ns/1ps
`include "page_map_consts.svh"
module program_space_page_mapper (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic fetch_req,
  input wire logic [`PC_WIDTH-1:0] program_counter,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic data_bit_op,
  input wire logic [`DATA_ADDR_WIDTH-1:0] data_addr,
  input wire logic [`DATA_WIDTH-1:0] data_wdata,
  output logic fetch_valid,
  output logic [`PHYS_WIDTH-1:0] phys_addr,
  output logic static_hit,
  output logic page_unknown,
  output logic page_known,
  output logic access_refused
);
  typedef struct packed {
    page_map_pkg::sel_state_t st;
    page_map_pkg::page_t sel;
    page_map_pkg::phys_t phys;
    logic valid;
    logic hit;
    logic unknown;
    logic refused;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic sel_hit;
  logic good_wr;

  page_map_if map ();

  page_decode u_decode (
    .map(map)
  );

  // The program counter and the page select code drive the decoder
  assign map.pc = program_counter;
  assign map.code = s_q.sel;

  assign sel_hit = data_addr == `PAGE_SEL_ADDR;
  // Whole-byte writes only reach the register
  assign good_wr = data_wr && sel_hit && !data_bit_op;

  always_comb begin
    s_d = s_q;
    s_d.valid = 1'b0;
    s_d.refused = 1'b0;
    if (fetch_req) begin
      s_d.valid = 1'b1;
      s_d.phys = map.phys;
      s_d.hit = map.upper_hit;
      // Lower range fetch before any write has no defined page
      s_d.unknown = !map.upper_hit && (s_q.st == page_map_pkg::SEL_UNKNOWN);
    end
    // Reads and bit operations at the select address are refused
    if (sel_hit && (data_rd || (data_wr && data_bit_op))) begin
      s_d.refused = 1'b1;
    end
    case (s_q.st)
      page_map_pkg::SEL_UNKNOWN: begin
        if (good_wr) begin
          s_d.st = page_map_pkg::SEL_KNOWN;
        end
      end
      page_map_pkg::SEL_KNOWN: begin
        s_d.st = page_map_pkg::SEL_KNOWN;
      end
      default: begin
        s_d.st = page_map_pkg::SEL_UNKNOWN;
      end
    endcase
    // Changed only by a software write, never by calls or interrupts
    if (good_wr) begin
      s_d.sel = data_wdata[`PAGE_SEL_LSB +: `PAGE_WIDTH];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.st <= page_map_pkg::SEL_UNKNOWN;
      s_q.sel <= `PAGE_SEL_RST;
      s_q.phys <= '0;
      s_q.valid <= 1'b0;
      s_q.hit <= 1'b0;
      s_q.unknown <= 1'b0;
      s_q.refused <= 1'b0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign fetch_valid = s_q.valid;
  assign phys_addr = s_q.phys;
  assign static_hit = s_q.hit;
  assign page_unknown = s_q.unknown;
  assign page_known = s_q.st == page_map_pkg::SEL_KNOWN;
  assign access_refused = s_q.refused;

  AST_FETCH_ANSWER: assert property (@(posedge clk) disable iff (rst)
    clk_en && fetch_req |=> fetch_valid)
    else $error("fetch not answered next cycle");

  AST_UPPER_STATIC: assert property (@(posedge clk) disable iff (rst)
    clk_en && fetch_req && program_counter[`PC_MSB]
    |=> phys_addr[`PHYS_WIDTH-1 -: `PAGE_WIDTH] == `STATIC_PAGE && static_hit)
    else $error("upper range did not reach static page");

  AST_UPPER_IGNORES_SEL: assert property (@(posedge clk) disable iff (rst)
    clk_en && fetch_req && program_counter[`PC_MSB]
    |=> phys_addr == {`STATIC_PAGE, $past(program_counter[`OFFSET_WIDTH-1:0])})
    else $error("upper range depends on page select");

  AST_LOWER_CODE: assert property (@(posedge clk) disable iff (rst)
    clk_en && fetch_req && !program_counter[`PC_MSB]
    |=> phys_addr[`PHYS_WIDTH-1 -: `PAGE_WIDTH] == $past(s_q.sel) && !static_hit)
    else $error("lower range page differs from select code");

  AST_SAME_STORAGE: assert property (@(posedge clk) disable iff (rst)
    clk_en && fetch_req && !program_counter[`PC_MSB] && s_q.sel == `STATIC_PAGE
    |=> phys_addr == {`STATIC_PAGE, $past(program_counter[`OFFSET_WIDTH-1:0])})
    else $error("code 01 lower fetch misses static page");

  AST_OFFSET_KEPT: assert property (@(posedge clk) disable iff (rst)
    clk_en && fetch_req
    |=> phys_addr[`OFFSET_WIDTH-1:0] == $past(program_counter[`OFFSET_WIDTH-1:0]))
    else $error("in-page offset altered");

  AST_WRITE_LOADS: assert property (@(posedge clk) disable iff (rst)
    clk_en && good_wr
    |=> s_q.sel == $past(data_wdata[`PAGE_SEL_LSB +: `PAGE_WIDTH]) && page_known)
    else $error("page select write not taken");

  AST_REFUSED: assert property (@(posedge clk) disable iff (rst)
    clk_en && sel_hit && (data_rd || (data_wr && data_bit_op))
    |=> access_refused && $stable(s_q.sel))
    else $error("read or bit operation not refused");

  AST_SEL_HOLDS: assert property (@(posedge clk) disable iff (rst)
    !(clk_en && good_wr) |=> $stable(s_q.sel))
    else $error("page select changed without a write");

  AST_UNKNOWN_FLAG: assert property (@(posedge clk) disable iff (rst)
    clk_en && fetch_req && !program_counter[`PC_MSB] && !page_known
    |=> page_unknown)
    else $error("lower fetch before first write not flagged");

  AST_PAGE_NUMBER: assert property (@(posedge clk) disable iff (rst)
    clk_en && fetch_req && !program_counter[`PC_MSB] && s_q.sel == 2'h2
    |=> phys_addr[`PHYS_WIDTH-1 -: `PAGE_WIDTH] == 2'h2)
    else $error("code 10 not mapped to page 2");

  AST_PAGE_ZERO: assert property (@(posedge clk) disable iff (rst)
    clk_en && fetch_req && !program_counter[`PC_MSB] && s_q.sel == 2'h0
    |=> phys_addr[`PHYS_WIDTH-1 -: `PAGE_WIDTH] == 2'h0)
    else $error("code 00 not mapped to page 0");

  AST_PAGE_ONE: assert property (@(posedge clk) disable iff (rst)
    clk_en && fetch_req && !program_counter[`PC_MSB] && s_q.sel == 2'h1
    |=> phys_addr[`PHYS_WIDTH-1 -: `PAGE_WIDTH] == 2'h1)
    else $error("code 01 not mapped to page 1");

  AST_PAGE_THREE: assert property (@(posedge clk) disable iff (rst)
    clk_en && fetch_req && !program_counter[`PC_MSB] && s_q.sel == 2'h3
    |=> phys_addr[`PHYS_WIDTH-1 -: `PAGE_WIDTH] == 2'h3)
    else $error("code 11 not mapped to page 3");

  AST_HIT_MATCHES: assert property (@(posedge clk) disable iff (rst)
    clk_en && fetch_req
    |=> static_hit == $past(program_counter[`PC_MSB]))
    else $error("static hit differs from counter bit 11");

  AST_VALID_DROPS: assert property (@(posedge clk) disable iff (rst)
    clk_en && !fetch_req
    |=> !fetch_valid)
    else $error("fetch valid without a fetch");

  AST_PHYS_HOLDS: assert property (@(posedge clk) disable iff (rst)
    !(clk_en && fetch_req)
    |=> $stable(phys_addr) && $stable(static_hit))
    else $error("address changed without a fetch");

  AST_FREEZE: assert property (@(posedge clk) disable iff (rst)
    !clk_en
    |=> $stable(s_q))
    else $error("state moved while clock enable low");

  AST_NO_REFUSE: assert property (@(posedge clk) disable iff (rst)
    clk_en && !(sel_hit && (data_rd || (data_wr && data_bit_op)))
    |=> !access_refused)
    else $error("refusal without a bad access");

  AST_OTHER_ADDR: assert property (@(posedge clk) disable iff (rst)
    clk_en && data_wr && !sel_hit
    |=> $stable(s_q.sel) && $stable(page_known))
    else $error("write elsewhere touched page select");

  AST_UPPER_KNOWN: assert property (@(posedge clk) disable iff (rst)
    clk_en && fetch_req && program_counter[`PC_MSB]
    |=> !page_unknown)
    else $error("upper fetch flagged as unknown page");

  AST_KNOWN_CLEAR: assert property (@(posedge clk) disable iff (rst)
    clk_en && fetch_req && page_known
    |=> !page_unknown)
    else $error("fetch after write flagged as unknown");

  AST_KNOWN_STAYS: assert property (@(posedge clk) disable iff (rst)
    page_known
    |=> page_known)
    else $error("known page lost without reset");

  AST_RESET_CLEARS: assert property (@(posedge clk)
    rst
    |=> !fetch_valid && !page_known && !page_unknown && !access_refused && phys_addr == '0)
    else $error("reset did not clear outputs");

  AST_WRITE_THEN_FETCH: assert property (@(posedge clk) disable iff (rst)
    clk_en && good_wr ##1 clk_en && !good_wr
    ##1 clk_en && fetch_req && !program_counter[`PC_MSB]
    |=> phys_addr[`PHYS_WIDTH-1 -: `PAGE_WIDTH]
    == $past(data_wdata[`PAGE_SEL_LSB +: `PAGE_WIDTH], 3))
    else $error("fetch after write missed new code");
endmodule

// ==== bench/core_model.sv ====
// Core fetch and page select write model
`timescale 1ns/1ps
`include "page_map_consts.svh"
module core_model (
  input wire logic clk,
  output logic fetch_req,
  output logic [`PC_WIDTH-1:0] program_counter,
  output logic data_wr,
  output logic data_rd,
  output logic data_bit_op,
  output logic [`DATA_ADDR_WIDTH-1:0] data_addr,
  output logic [`DATA_WIDTH-1:0] data_wdata
);
  initial begin
    {fetch_req, data_wr, data_rd, data_bit_op} = 4'h0;
    program_counter = 12'h000;
    data_addr = 8'h00;
    data_wdata = 8'h00;
  end
  // One fetch, then the address lines scramble
  task automatic fetch(input logic [`PC_WIDTH-1:0] pc);
    @(posedge clk) #1;
    fetch_req = 1'b1;
    program_counter = pc;
    @(posedge clk) #1;
    fetch_req = 1'b0;
    program_counter = ~pc;
  endtask
  // One data access, then the data lines scramble
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic [2:0] wrb);
    @(posedge clk) #1;
    {data_wr, data_rd, data_bit_op} = wrb;
    data_addr = a;
    data_wdata = d;
    @(posedge clk) #1;
    {data_wr, data_rd, data_bit_op} = 3'h0;
    data_addr = ~a;
    data_wdata = ~d;
  endtask
endmodule

// ==== bench/program_space_page_mapper_test.sv ====
// Self-checking bench for the program space page mapper
`timescale 1ns/1ps
`include "page_map_consts.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module program_space_page_mapper_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic fetch_req, data_wr, data_rd, data_bit_op;
  logic [`PC_WIDTH-1:0] program_counter;
  logic [7:0] data_addr, data_wdata;
  logic fetch_valid, static_hit, page_unknown, page_known, access_refused;
  logic [`PHYS_WIDTH-1:0] phys_addr;
  int n_fail = 0;
  int n_checks = 0;
  initial begin
    forever #20 clk = ~clk;
  end
  core_model u_core (.clk(clk), .fetch_req(fetch_req), .program_counter(program_counter),
    .data_wr(data_wr), .data_rd(data_rd), .data_bit_op(data_bit_op),
    .data_addr(data_addr), .data_wdata(data_wdata));
  program_space_page_mapper u_dut (.clk(clk), .rst(rst), .clk_en(clk_en),
    .fetch_req(fetch_req), .program_counter(program_counter), .data_wr(data_wr),
    .data_rd(data_rd), .data_bit_op(data_bit_op), .data_addr(data_addr),
    .data_wdata(data_wdata), .fetch_valid(fetch_valid), .phys_addr(phys_addr),
    .static_hit(static_hit), .page_unknown(page_unknown), .page_known(page_known),
    .access_refused(access_refused));
  task automatic fetch_chk(input logic [11:0] pc, input logic [12:0] ex);
    u_core.fetch(pc);
    `CHK("fetch_valid", 1'b1, fetch_valid)
    `CHK("phys_addr", ex, phys_addr)
    `CHK("static_hit", pc[11], static_hit)
  endtask
  task automatic t_after_reset();
    `CHK("page_known", 1'b0, page_known)
    fetch_chk(12'h834, 13'h0834);
    fetch_chk(12'h010, 13'h0010);
    `CHK("page_unknown", 1'b1, page_unknown)
  endtask
  task automatic t_codes();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      u_core.access(8'hCA, {6'h3F, c}, 3'h4);
      `CHK("page_known", 1'b1, page_known)
      fetch_chk(12'h7FF, {c, 11'h7FF});
      `CHK("page_unknown", 1'b0, page_unknown)
      fetch_chk(12'h000, {c, 11'h000});
      fetch_chk(12'hFFE, 13'h0FFE);
    end
    u_core.access(8'hCA, 8'h01, 3'h4);
    fetch_chk(12'h123, 13'h0923);
    fetch_chk(12'h923, 13'h0923);
  endtask
  task automatic t_refused();
    u_core.access(8'hCA, 8'h02, 3'h4);
    u_core.access(8'hCA, 8'h03, 3'h2);
    `CHK("access_refused", 1'b1, access_refused)
    u_core.access(8'hCA, 8'h03, 3'h5);
    `CHK("access_refused", 1'b1, access_refused)
    u_core.access(8'hCB, 8'h03, 3'h4);
    `CHK("access_refused", 1'b0, access_refused)
    fetch_chk(12'hFF0, 13'h0FF0);
    fetch_chk(12'h010, 13'h1010);
  endtask
  task automatic t_freeze();
    @(posedge clk) #1;
    clk_en = 1'b0;
    u_core.access(8'hCA, 8'h03, 3'h4);
    u_core.fetch(12'h020);
    `CHK("fetch_valid", 1'b0, fetch_valid)
    `CHK("phys_addr", 13'h1010, phys_addr)
    `CHK("page_known", 1'b1, page_known)
    clk_en = 1'b1;
    fetch_chk(12'h020, 13'h1020);
  endtask
  task automatic t_reset_again();
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    `CHK("page_known", 1'b0, page_known)
    `CHK("fetch_valid", 1'b0, fetch_valid)
    `CHK("access_refused", 1'b0, access_refused)
    fetch_chk(12'hFFF, 13'h0FFF);
    `CHK("page_unknown", 1'b0, page_unknown)
    fetch_chk(12'h555, 13'h0555);
    `CHK("page_unknown", 1'b1, page_unknown)
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    t_after_reset();
    t_codes();
    t_refused();
    t_freeze();
    t_reset_again();
    finish_test();
  end
  initial begin
    #(40 * 2000);
    n_fail++;
    finish_test();
  end
endmodule
